// ### hw/status_pkg.sv
package status_pkg;

    // Width of the flag register and of an operand
    localparam int DATA_W = 8;

    // Flag bit positions
    localparam int C_BIT = 0;
    localparam int DC_BIT = 1;
    localparam int Z_BIT = 2;
    localparam int PD_BIT = 3;
    localparam int TO_BIT = 4;
    localparam int FLAG_W = 5;

    // Width of the low nibble whose carry-out drives the digit flag
    localparam int NIBBLE_W = 4;

    // Flag value after power-up: expiry and sleep flags set, others clear
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h18;

    // Register byte offsets on the bus
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PROBE = 8'h0c;

    // Command register fields
    localparam int CMD_A_LSB = 0;
    localparam int CMD_B_LSB = 8;
    localparam int CMD_OP_LSB = 16;
    localparam int CMD_DEST_BIT = 20;
    localparam int CMD_SEL_LSB = 21;
    localparam int SEL_W = 3;

    // Bank-relative data memory map
    localparam int MEM_ADDR_W = 7;
    localparam logic [MEM_ADDR_W-1:0] CORE_LAST = 7'h0b;
    localparam logic [MEM_ADDR_W-1:0] PERIPH_FIRST = 7'h0c;
    localparam logic [MEM_ADDR_W-1:0] PERIPH_LAST = 7'h1f;

    // Probe answer bits
    localparam int PROBE_CORE_BIT = 0;
    localparam int PROBE_PERIPH_BIT = 1;
    localparam int PROBE_RAM_BIT = 2;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operations the flag datapath knows
    typedef enum logic [3:0] {
        OP_ADD = 4'b0000,
        OP_SUB = 4'b0001,
        OP_AND = 4'b0010,
        OP_OR = 4'b0011,
        OP_XOR = 4'b0100,
        OP_ROR = 4'b0101,
        OP_ROL = 4'b0110,
        OP_CLR = 4'b0111,
        OP_MOVE = 4'b1000,
        OP_BITZ = 4'b1001,
        OP_BITO = 4'b1010,
        OP_SWAP = 4'b1011
    } op_e;

endpackage : status_pkg

// ### hw/alu_if.sv
`timescale 1ns/1ps
`default_nettype none
// Operands in, result and flag verdicts out
interface alu_if;
    logic [status_pkg::DATA_W-1:0] a;      // File operand
    logic [status_pkg::DATA_W-1:0] b;      // Work operand
    status_pkg::op_e op;                   // Operation
    logic [status_pkg::SEL_W-1:0] sel;     // Bit index for bit ops
    logic carry_in;                        // Current carry flag
    logic [status_pkg::DATA_W-1:0] result; // Operation result
    logic z;                               // Zero verdict
    logic dc;                              // Digit carry verdict
    logic c;                               // Carry verdict
    logic z_hit;                           // Operation owns zero flag
    logic dc_hit;                          // Operation owns digit flag
    logic c_hit;                           // Operation owns carry flag

    modport alu (input a, b, op, sel, carry_in,
                 output result, z, dc, c, z_hit, dc_hit, c_hit);
    modport user (output a, b, op, sel, carry_in,
                  input result, z, dc, c, z_hit, dc_hit, c_hit);
endinterface : alu_if
`default_nettype wire

// ### hw/flag_alu.sv
`timescale 1ns/1ps
`default_nettype none
// Combinational datapath producing a result and its flags
module flag_alu (
    alu_if.alu bus
);
    localparam int NW = status_pkg::NIBBLE_W;
    localparam int DW = status_pkg::DATA_W;

    logic [NW:0] nib_sum;  // Low nibble sum with carry-out
    logic [DW:0] full_sum; // Full sum with carry-out
    logic [DW-1:0] addend; // Second operand, complemented for subtract
    logic sub_in;          // Carry-in that completes two's complement

    // Result and flag selection per operation
    always_comb begin
        sub_in = (bus.op == status_pkg::OP_SUB);
        addend = sub_in ? ~bus.b : bus.b;
        nib_sum = {1'b0, bus.a[NW-1:0]} + {1'b0, addend[NW-1:0]}
                  + {{NW{1'b0}}, sub_in};
        full_sum = {1'b0, bus.a} + {1'b0, addend} + {{DW{1'b0}}, sub_in};
        bus.result = '0;
        bus.dc = nib_sum[NW];
        bus.c = full_sum[DW];
        bus.z_hit = 1'b1;
        bus.dc_hit = 1'b0;
        bus.c_hit = 1'b0;
        case (bus.op)
            status_pkg::OP_ADD, status_pkg::OP_SUB: begin
                bus.result = full_sum[DW-1:0];
                bus.dc_hit = 1'b1;
                bus.c_hit = 1'b1;
            end
            status_pkg::OP_AND: bus.result = bus.a & bus.b;
            status_pkg::OP_OR: bus.result = bus.a | bus.b;
            status_pkg::OP_XOR: bus.result = bus.a ^ bus.b;
            status_pkg::OP_CLR: bus.result = '0;
            status_pkg::OP_ROR: begin
                // Low bit leaves into carry
                bus.result = {bus.carry_in, bus.a[DW-1:1]};
                bus.c = bus.a[0];
                bus.c_hit = 1'b1;
                bus.z_hit = 1'b0;
            end
            status_pkg::OP_ROL: begin
                // High bit leaves into carry
                bus.result = {bus.a[DW-2:0], bus.carry_in};
                bus.c = bus.a[DW-1];
                bus.c_hit = 1'b1;
                bus.z_hit = 1'b0;
            end
            status_pkg::OP_MOVE: begin
                bus.result = bus.b;
                bus.z_hit = 1'b0;
            end
            status_pkg::OP_BITZ: begin
                bus.result = bus.a & ~(8'h01 << bus.sel);
                bus.z_hit = 1'b0;
            end
            status_pkg::OP_BITO: begin
                bus.result = bus.a | (8'h01 << bus.sel);
                bus.z_hit = 1'b0;
            end
            status_pkg::OP_SWAP: begin
                bus.result = {bus.a[NW-1:0], bus.a[DW-1:NW]};
                bus.z_hit = 1'b0;
            end
            default: bus.z_hit = 1'b0;
        endcase
        bus.z = (bus.result == '0);
    end
endmodule : flag_alu
`default_nettype wire

// ### hw/core_status_flags.sv
// Summary of operation
// - Expiry flag set by power-up, kick, sleep
// - Watchdog expiry clears the expiry flag
// - Zero flag follows zero result
// - Digit flag is carry out of low nibble
// - Carry flag is carry out of top bit
// - Subtract adds complement; carries mean no borrow
// - Rotates load carry with shifted-out bit
// - Clearing status gives 000u u1uu
// - Peripheral registers sit at 0x0c to 0x1f
// - Flag-owning ops override data write to flags
// - Expiry and sleep flags ignore software writes
`timescale 1ns/1ps
`default_nettype none
module core_status_flags (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic watchdog_kick_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_expiry,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [7:0] status_flags
);
    localparam int FW = status_pkg::FLAG_W;
    localparam int DW = status_pkg::DATA_W;

    // Classify a bank-relative data address
    function automatic logic [2:0] classify(
        input logic [status_pkg::MEM_ADDR_W-1:0] addr);
        logic [2:0] cls;
        cls = '0;
        if (addr <= status_pkg::CORE_LAST) begin
            cls[status_pkg::PROBE_CORE_BIT] = 1'b1;
        end else if (addr <= status_pkg::PERIPH_LAST) begin
            cls[status_pkg::PROBE_PERIPH_BIT] = 1'b1;
        end else begin
            cls[status_pkg::PROBE_RAM_BIT] = 1'b1;
        end
        return cls;
    endfunction : classify

    // Merge written byte lanes into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    alu_if alu_bus ();  // Link to the datapath
    flag_alu flag_alu_inst (.bus(alu_bus));

    logic [FW-1:0] flags, next_flags;      // Implemented flag bits
    logic [DW-1:0] result, next_result;    // Last operation result
    logic [31:0] cmd, next_cmd;            // Held command word
    logic [status_pkg::MEM_ADDR_W-1:0] probe, next_probe; // Probe address
    logic aw_held, next_aw_held;           // Write address captured
    logic w_held, next_w_held;             // Write data captured
    logic [7:0] aw_addr, next_aw_addr;     // Captured write address
    logic [31:0] w_data, next_w_data;      // Captured write data
    logic [3:0] w_strb, next_w_strb;       // Captured byte enables
    logic bvalid, next_bvalid;             // Write answer pending
    logic [1:0] bresp, next_bresp;         // Write answer code
    logic rvalid, next_rvalid;             // Read answer pending
    logic [1:0] rresp, next_rresp;         // Read answer code
    logic [31:0] rdata, next_rdata;        // Read answer data
    logic awready, next_awready;           // Address channel ready
    logic wready, next_wready;             // Data channel ready
    logic arready, next_arready;           // Read address ready
    logic wr_fire;                         // Write performed this cycle
    logic exec;                            // Command executes this cycle
    logic [31:0] cmd_word;                 // Command after lane merge
    logic dest_status;                     // Result goes to status

    // Datapath operands from the merged command word
    always_comb begin
        wr_fire = aw_held && w_held && !bvalid;
        cmd_word = merge(cmd, w_data, w_strb);
        exec = wr_fire && (aw_addr == status_pkg::OFF_CMD);
        dest_status = cmd_word[status_pkg::CMD_DEST_BIT];
        // Status as destination reads its own current value
        alu_bus.a = dest_status ? {3'h0, flags}
                    : cmd_word[status_pkg::CMD_A_LSB +: DW];
        alu_bus.b = cmd_word[status_pkg::CMD_B_LSB +: DW];
        alu_bus.op = status_pkg::op_e'(cmd_word[status_pkg::CMD_OP_LSB +: 4]);
        alu_bus.sel = cmd_word[status_pkg::CMD_SEL_LSB +: status_pkg::SEL_W];
        alu_bus.carry_in = flags[status_pkg::C_BIT];
    end

    // Flag, result and register next values
    always_comb begin
        next_flags = flags;
        next_result = result;
        next_cmd = cmd;
        next_probe = probe;
        if (exec) begin
            next_cmd = cmd_word;
            next_result = alu_bus.result;
            if (dest_status) begin
                // Data write to low flags; top flags never written
                next_flags[status_pkg::Z_BIT:0] = alu_bus.result[2:0];
            end
            // Flag logic wins over a data write to the flags
            if (alu_bus.z_hit) begin
                next_flags[status_pkg::Z_BIT] = alu_bus.z;
            end else if (dest_status && (alu_bus.dc_hit || alu_bus.c_hit)) begin
                next_flags[status_pkg::Z_BIT] = flags[status_pkg::Z_BIT];
            end
            if (alu_bus.dc_hit) begin
                next_flags[status_pkg::DC_BIT] = alu_bus.dc;
            end else if (dest_status && (alu_bus.z_hit || alu_bus.c_hit)) begin
                next_flags[status_pkg::DC_BIT] = flags[status_pkg::DC_BIT];
            end
            if (alu_bus.c_hit) begin
                next_flags[status_pkg::C_BIT] = alu_bus.c;
            end else if (dest_status && (alu_bus.z_hit || alu_bus.dc_hit)) begin
                next_flags[status_pkg::C_BIT] = flags[status_pkg::C_BIT];
            end
        end else if (wr_fire && aw_addr == status_pkg::OFF_STATUS) begin
            // Direct write moves the low flags only
            if (w_strb[0]) begin
                next_flags[status_pkg::Z_BIT:0] = w_data[2:0];
            end
        end else if (wr_fire && aw_addr == status_pkg::OFF_PROBE) begin
            if (w_strb[0]) begin
                next_probe = w_data[status_pkg::MEM_ADDR_W-1:0];
            end
        end
        // Hardware events; expiry has the last word
        if (watchdog_kick_instr || sleep_instr) begin
            next_flags[status_pkg::TO_BIT] = 1'b1;
        end
        if (sleep_instr) begin
            next_flags[status_pkg::PD_BIT] = 1'b0;
        end
        if (watchdog_expiry) begin
            next_flags[status_pkg::TO_BIT] = 1'b0;
        end
    end

    // Bus channel next values
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        // Capture address and data in either order
        if (s_axi_awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            // Result register is read-only; unmapped gets an error
            if (aw_addr == status_pkg::OFF_STATUS
                || aw_addr == status_pkg::OFF_CMD
                || aw_addr == status_pkg::OFF_PROBE) begin
                next_bresp = status_pkg::RESP_OKAY;
            end else begin
                next_bresp = status_pkg::RESP_SLVERR;
            end
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = status_pkg::RESP_OKAY;
            next_rdata = '0;
            if (s_axi_araddr == status_pkg::OFF_STATUS) begin
                next_rdata[DW-1:0] = {3'h0, flags};
            end else if (s_axi_araddr == status_pkg::OFF_CMD) begin
                next_rdata = cmd;
            end else if (s_axi_araddr == status_pkg::OFF_RESULT) begin
                next_rdata[DW-1:0] = result;
            end else if (s_axi_araddr == status_pkg::OFF_PROBE) begin
                next_rdata[2:0] = classify(probe);
            end else begin
                next_rresp = status_pkg::RESP_SLVERR;
            end
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // Registers; reset is the power-up event
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flags <= status_pkg::FLAGS_RESET;
            result <= '0;
            cmd <= '0;
            probe <= '0;
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            bvalid <= 1'b0;
            bresp <= status_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= status_pkg::RESP_OKAY;
            rdata <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
        end else begin
            flags <= next_flags;
            result <= next_result;
            cmd <= next_cmd;
            probe <= next_probe;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            awready <= next_awready;
            wready <= next_wready;
            arready <= next_arready;
        end
    end

    // Outputs straight from flip-flops
    always_comb begin
        s_axi_awready = awready;
        s_axi_wready = wready;
        s_axi_bvalid = bvalid;
        s_axi_bresp = bresp;
        s_axi_arready = arready;
        s_axi_rvalid = rvalid;
        s_axi_rresp = rresp;
        s_axi_rdata = rdata;
        status_flags = {3'h0, flags};
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic quiet;     // No hardware flag events
    logic [8:0] sum_ref; // Reference sum
    assign quiet = !watchdog_kick_instr && !sleep_instr && !watchdog_expiry;
    assign sum_ref = {1'b0, alu_bus.a} + {1'b0, alu_bus.b};

    sequence s_status_write;
        wr_fire && aw_addr == status_pkg::OFF_STATUS && quiet;
    endsequence
    sequence s_clear_status;
        exec && dest_status && alu_bus.op == status_pkg::OP_CLR && quiet;
    endsequence

    unimpl_zero_a: assert property (status_flags[7:5] == 3'h0)
        else $error("upper status bits not zero");
    kick_sets_a: assert property ((watchdog_kick_instr
        && !watchdog_expiry) |=> status_flags[4])
        else $error("kick did not set expiry flag");
    expiry_clears_a: assert property (watchdog_expiry
        |=> !status_flags[4] && $past(status_flags[3]) == status_flags[3]
            || $past(sleep_instr))
        else $error("expiry did not clear flag");
    sleep_flags_a: assert property ((sleep_instr && !watchdog_expiry)
        |=> !status_flags[3] && status_flags[4])
        else $error("sleep flags wrong");
    sw_ignored_a: assert property (s_status_write
        |=> $stable(status_flags[4:3]))
        else $error("software changed hardware flags");
    clear_pattern_a: assert property (s_clear_status
        |=> status_flags[7:5] == 3'h0 && status_flags[2]
            && status_flags[1:0] == $past(status_flags[1:0]))
        else $error("clear pattern wrong");
    add_carry_a: assert property (exec && !dest_status
        && alu_bus.op == status_pkg::OP_ADD
        |=> status_flags[0] == $past(sum_ref[8])
            && status_flags[1] == $past(alu_bus.a[3:0] + alu_bus.b[3:0] > 15))
        else $error("add carry flags wrong");
    sub_borrow_a: assert property (exec && !dest_status
        && alu_bus.op == status_pkg::OP_SUB
        |=> status_flags[0] == $past(alu_bus.a >= alu_bus.b))
        else $error("borrow polarity wrong");
    rotate_carry_a: assert property (exec && alu_bus.op
        == status_pkg::OP_ROR |=> status_flags[0] == $past(alu_bus.a[0]))
        else $error("rotate carry wrong");
    zero_flag_a: assert property (exec && !dest_status
        && alu_bus.op == status_pkg::OP_XOR
        |=> status_flags[2] == (result == 8'h00))
        else $error("zero flag wrong");
    flag_override_a: assert property (exec && dest_status
        && alu_bus.op == status_pkg::OP_AND
        |=> status_flags[1:0] == $past(status_flags[1:0]))
        else $error("data write reached flag bits");
endmodule : core_status_flags
`default_nettype wire

// ### tb/core_status_flags_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Compare a seen value with the expected one and count the outcome
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
    end end
module core_status_flags_bench;
    logic mclk = 1'b0; // Core clock
    logic sys_rst = 1'b1; // Power-up reset
    logic kick = 1'b0; // Watchdog kick pulse
    logic slp = 1'b0; // Sleep pulse
    logic wdx = 1'b0; // Watchdog expiry pulse
    logic [7:0] awaddr = 8'h00; // Write address
    logic [7:0] araddr = 8'h00; // Read address
    logic [31:0] wdata = 32'h0; // Write data
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // Write handshakes
    logic arvalid = 1'b0, rready = 1'b0; // Read handshakes
    logic awready, wready, bvalid, arready, rvalid; // Slave answers
    logic [1:0] bresp, rresp, rs; // Responses and last one seen
    logic [31:0] rdata, rd; // Read data and last word read
    logic [7:0] flags; // Status register output
    int num_errors = 0; // Mismatches
    int n_tests = 0; // Comparisons
    // Probe addresses and the class bit each must report
    logic [7:0] pa [4] = '{8'h0b, 8'h0c, 8'h1f, 8'h20};
    logic [2:0] pe [4] = '{3'h1, 3'h2, 3'h2, 3'h4};

    // Clock at 25 MHz
    always #20 mclk = ~mclk;

    core_status_flags core_status_flags_inst (
        .mclk(mclk), .sys_rst(sys_rst), .watchdog_kick_instr(kick),
        .sleep_instr(slp), .watchdog_expiry(wdx),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .status_flags(flags)
    );

    // Print counts and verdict, then stop
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // Bus write; address and data held until each is taken
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while ((awvalid && awready !== 1'b1) ||
                   (wvalid && wready !== 1'b1));
        do @(posedge mclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    // Bus read; data taken at the edge that sees rvalid
    task automatic axi_rd(input logic [7:0] ad);
        @(posedge mclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // Run one operation, then check result and flags
    task automatic op(input status_pkg::op_e o, input logic [7:0] a, b,
                      input logic d, input logic [7:0] er, es);
        // Bit ops take their index from the low bits of b
        axi_wr(status_pkg::OFF_CMD, {8'h00, b[2:0], d, o, b, a});
        `CHK("cmd resp", status_pkg::RESP_OKAY, rs)
        axi_rd(status_pkg::OFF_RESULT);
        `CHK("result", er, rd[7:0])
        `CHK("flags", es, flags)
    endtask : op

    // Pulse events {kick, sleep, expiry} for one cycle, then check flags
    task automatic ev(input logic [2:0] m, input logic [7:0] es);
        @(posedge mclk);
        {kick, slp, wdx} <= m;
        @(posedge mclk);
        {kick, slp, wdx} <= 3'h0;
        @(posedge mclk);
        `CHK("event flags", es, flags)
    endtask : ev

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        `CHK("reset flags", 8'h18, flags)
        axi_rd(status_pkg::OFF_STATUS);
        `CHK("reset read", 32'h18, rd)
        $display("test reset done");
        op(status_pkg::OP_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 8'h1a);
        op(status_pkg::OP_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 8'h1f);
        op(status_pkg::OP_SUB, 8'h10, 8'h01, 1'b0, 8'h0f, 8'h19);
        op(status_pkg::OP_SUB, 8'h00, 8'h01, 1'b0, 8'hff, 8'h18);
        op(status_pkg::OP_ROR, 8'h01, 8'h00, 1'b0, 8'h00, 8'h19);
        op(status_pkg::OP_ROL, 8'h80, 8'h00, 1'b0, 8'h01, 8'h19);
        op(status_pkg::OP_AND, 8'hf0, 8'h0f, 1'b0, 8'h00, 8'h1d);
        op(status_pkg::OP_OR, 8'h30, 8'h03, 1'b0, 8'h33, 8'h19);
        op(status_pkg::OP_XOR, 8'h55, 8'h55, 1'b0, 8'h00, 8'h1d);
        $display("test alu done");
        axi_wr(status_pkg::OFF_STATUS, 32'he2);
        axi_rd(status_pkg::OFF_STATUS);
        `CHK("status write", 32'h1a, rd)
        op(status_pkg::OP_CLR, 8'h55, 8'h00, 1'b1, 8'h00, 8'h1e);
        op(status_pkg::OP_MOVE, 8'h00, 8'h05, 1'b1, 8'h05, 8'h1d);
        op(status_pkg::OP_ADD, 8'h00, 8'h01, 1'b1, 8'h1e, 8'h18);
        op(status_pkg::OP_BITO, 8'h00, 8'h00, 1'b1, 8'h19, 8'h19);
        op(status_pkg::OP_BITZ, 8'h00, 8'h00, 1'b1, 8'h18, 8'h18);
        op(status_pkg::OP_SWAP, 8'h00, 8'h00, 1'b1, 8'h81, 8'h19);
        op(status_pkg::OP_AND, 8'h00, 8'h06, 1'b1, 8'h00, 8'h1d);
        op(status_pkg::OP_BITO, 8'h00, 8'h02, 1'b0, 8'h04, 8'h1d);
        op(status_pkg::OP_MOVE, 8'h00, 8'h00, 1'b1, 8'h00, 8'h18);
        $display("test destination done");
        ev(3'b010, 8'h10);
        ev(3'b001, 8'h00);
        ev(3'b100, 8'h10);
        ev(3'b101, 8'h00);
        ev(3'b010, 8'h10);
        axi_wr(status_pkg::OFF_STATUS, 32'h18);
        `CHK("sw write", 8'h10, flags)
        @(posedge mclk);
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        `CHK("second reset", 8'h18, flags)
        $display("test events done");
        for (int i = 0; i < 4; i++) begin
            axi_wr(status_pkg::OFF_PROBE, {24'h0, pa[i]});
            axi_rd(status_pkg::OFF_PROBE);
            `CHK("probe", pe[i], rd[2:0])
        end
        $display("test map done");
        axi_rd(8'h10);
        `CHK("unmapped read", status_pkg::RESP_SLVERR, rs)
        axi_wr(status_pkg::OFF_RESULT, 32'h0);
        `CHK("result write", status_pkg::RESP_SLVERR, rs)
        axi_wr(8'h14, 32'h0);
        `CHK("unmapped write", status_pkg::RESP_SLVERR, rs)
        $display("test errors done");
        end_of_test();
    end
endmodule : core_status_flags_bench
`default_nettype wire
